// *** rtl/watchdog_code_trigger_regs_map.svh ***
// register offsets, reset values and fixed codes of the watchdog block
`ifndef WATCHDOG_CODE_TRIGGER_REGS_MAP_SVH
`define WATCHDOG_CODE_TRIGGER_REGS_MAP_SVH
// byte offsets on the register bus
`define OFS_CODE_TRIGGER 4'h4
`define OFS_REFERENCE 4'h8
`define OFS_MODE 4'hC
// code register reset pattern and the read value with the option off
`define CODE_RST 8'h2C
`define CODE_OFF_READ 8'h2C
`define REF_OFF_READ 8'h00
`define REF_RST 8'h00
`define REF_STEP 8'h01
// activation code = reference value xor this mask
`define ACODE_XOR 8'hAC
// mode field positions
`define MODE_RSVD_BIT 7
`define MODE_DIV_LSB 4
`define MODE_WIE_BIT 3
`define MODE_ERM_BIT 2
`define MODE_WS_LSB 0
// count clock divisor is two to the power of this base plus the field
`define DIV_BASE 5'd9
// axi4-lite answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** rtl/watchdog_code_trigger_regs_pkg.sv ***
// types shared by the watchdog register block
package watchdog_code_trigger_regs_pkg;
    // mode register layout, msb first
    typedef struct packed {
        logic rsvd;
        logic [2:0] div_sel;
        logic wie;
        logic erm;
        logic [1:0] ws;
    } mode_t;
    // watchdog run state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_STOP = 3'b100
    } wd_state_t;
endpackage

// *** rtl/watchdog_code_trigger_regs.sv ***
// windowed watchdog with variable-code trigger, reference and mode regs
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_code_trigger_regs_map.svh"
// Function
// - option set selects code register as trigger
// - correct code write clears, restarts counter
// - eight-bit byte register, reset x0101100
// - run bit sticky until reset
// - run reset from position, run, type inputs
// - option off: read 2C, ignore writes
// - read last code; wrong code is error
// - reference value updated after every trigger
// - reference read-only, reads 00 when off
// - new mode takes effect at next trigger
// - changing mode after first trigger is error
// - mode resets 0xxxx1xx from start-up options
// - mode bit 7 reads zero, ignores writes
// - count clock is source over 2^(9+n)
// - mode bit 2 picks nmi or reset
// - bits 1:0 choose window 25..100 percent
// - warning pulse at 75 percent if enabled
// - trigger outside open window is error
// - any error stops counter until reset
module watchdog_code_trigger_regs
    import watchdog_code_trigger_regs_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int ADDR_W = 4
) (
    input wire logic sys_clk_i, // watchdog source clock
    input wire logic srst_i, // synchronous reset, high
    input wire logic watchdog_present_option_i, // strap: watchdog on
    input wire logic variable_code_option_i, // strap: code trigger used
    input wire logic trigger_position_option_i, // strap: start source
    input wire logic auto_run_option_i, // strap: auto start
    input wire logic trigger_type_input_i, // start type input
    input wire logic [2:0] divider_option_i, // strap: divider reset
    input wire logic warning_irq_option_i, // strap: warning enable
    input wire logic [1:0] window_size_option_i, // strap: window reset
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i, // write address
    input wire logic s_axi_awvalid_i, // write address valid
    output logic s_axi_awready_o, // write address ready
    input wire logic [31:0] s_axi_wdata_i, // write data
    input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
    input wire logic s_axi_wvalid_i, // write data valid
    output logic s_axi_wready_o, // write data ready
    output logic [1:0] s_axi_bresp_o, // write response
    output logic s_axi_bvalid_o, // write response valid
    input wire logic s_axi_bready_i, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr_i, // read address
    input wire logic s_axi_arvalid_i, // read address valid
    output logic s_axi_arready_o, // read address ready
    output logic [31:0] s_axi_rdata_o, // read data
    output logic [1:0] s_axi_rresp_o, // read response
    output logic s_axi_rvalid_o, // read data valid
    input wire logic s_axi_rready_i, // read data ready
    output logic warning_irq_o, // 75 percent pulse
    output logic error_nmi_request_o, // error pulse, nmi mode
    output logic error_reset_out_o // error pulse, reset mode
);
    // ------------------------------------------------------------
    // parameters and derived constants
    // ------------------------------------------------------------
    localparam int CMAX = (2 ** CNT_W) - 1;
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(CMAX);
    localparam logic [CNT_W-1:0] CNT_WARN = CNT_W'((CMAX * 3) / 4);
    localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(CMAX / 2);
    localparam logic [CNT_W-1:0] CNT_QTR = CNT_W'(CMAX / 4);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // the window split needs at least eight counter steps
    if (CNT_W < 3 || CNT_W > 24 || ADDR_W < 4) begin : g_bad_param
        $error("watchdog_code_trigger_regs: bad parameter");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    wd_state_t state_q;
    mode_t mode_q; // software view of the mode register
    mode_t act_q; // settings in force
    logic first_done_q; // a trigger has been taken
    logic mode_wr_q; // the one allowed mode write used
    logic [7:0] last_q; // last written code
    logic [7:0] ref_q; // reference value
    logic [15:0] presc_q;
    logic [CNT_W-1:0] cnt_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;

    // ------------------------------------------------------------
    // strap decode
    // ------------------------------------------------------------
    wire run_init = trigger_position_option_i ? trigger_type_input_i
                                              : auto_run_option_i;
    wire start_on_reset = watchdog_present_option_i &
                          variable_code_option_i & run_init;
    wire mode_t mode_init = '{rsvd: 1'b0, div_sel: divider_option_i,
                             wie: warning_irq_option_i, erm: 1'b1,
                             ws: window_size_option_i};

    // ------------------------------------------------------------
    // count clock and counter decode
    // ------------------------------------------------------------
    // divisor follows the settings in force, not the pending write
    wire [4:0] div_exp = `DIV_BASE + {2'b00, act_q.div_sel};
    wire [16:0] div_one = 17'd1 << div_exp;
    wire [15:0] div_mask = 16'(div_one - 17'd1);
    wire running = (state_q == ST_RUN);
    wire tick = running && ((presc_q & div_mask) == div_mask);
    wire overflow = tick && (cnt_q == CNT_MAX);
    wire warn_hit = tick && (cnt_q == CNT_WARN - 1'b1) && act_q.wie;
    // open window is the tail of the period; 100 percent until first
    wire [CNT_W-1:0] win_start =
        !first_done_q ? CNT_ZERO :
        (act_q.ws == 2'b00) ? CNT_WARN :
        (act_q.ws == 2'b01) ? CNT_HALF :
        (act_q.ws == 2'b10) ? CNT_QTR : CNT_ZERO;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid_o;
    wire wr_lane = wr_fire && wstrb0_q; // byte lane 0 carries the data
    wire wr_code_sel = (awaddr_q[3:0] == `OFS_CODE_TRIGGER);
    wire wr_ref_sel = (awaddr_q[3:0] == `OFS_REFERENCE);
    wire wr_mode_sel = (awaddr_q[3:0] == `OFS_MODE);
    wire wr_mapped = wr_code_sel || wr_ref_sel || wr_mode_sel;
    wire live = !(state_q == ST_STOP);
    // option off: code writes do nothing at all
    wire code_wr = wr_lane && wr_code_sel && variable_code_option_i &&
                   live;
    wire [7:0] exp_code = ref_q ^ `ACODE_XOR;
    wire code_ok = (wdata_q == exp_code);
    wire closed_hit = running && (cnt_q < win_start);
    wire trigger = code_wr && code_ok && !closed_hit;
    wire bad_code = code_wr && (!code_ok || closed_hit);
    wire mode_wr = wr_lane && wr_mode_sel && live;
    wire mode_chg = (wdata_q[6:0] != mode_q[6:0]);
    // one write is free before the first trigger; later changes fault
    wire bad_mode = mode_wr && mode_chg &&
                    (first_done_q || mode_wr_q);
    wire error = live && (bad_code || bad_mode || overflow);

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    wire [3:0] ra = s_axi_araddr_i[3:0];
    wire rd_code_sel = (ra == `OFS_CODE_TRIGGER);
    wire rd_ref_sel = (ra == `OFS_REFERENCE);
    wire rd_mode_sel = (ra == `OFS_MODE);
    wire rd_mapped = rd_code_sel || rd_ref_sel || rd_mode_sel;
    wire [7:0] code_view = variable_code_option_i ?
        {!(state_q == ST_IDLE), last_q[6:0]} : `CODE_OFF_READ;
    wire [7:0] ref_view = variable_code_option_i ? ref_q
                                                 : `REF_OFF_READ;
    wire [7:0] mode_view = {1'b0, mode_q[6:0]};
    wire [7:0] rd_byte = rd_code_sel ? code_view :
                         rd_ref_sel ? ref_view :
                         rd_mode_sel ? mode_view : 8'h00;
    wire rd_take = s_axi_arvalid_i && s_axi_arready_o;

    // ------------------------------------------------------------
    // axi4-lite write channels: hold address and data, answer after both
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `RESP_OKAY;
        end else begin
            s_axi_awready_o <= !aw_held_q &&
                !(s_axi_awvalid_i && s_axi_awready_o);
            s_axi_wready_o <= !w_held_q &&
                !(s_axi_wvalid_i && s_axi_wready_o);
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata_i[7:0];
                wstrb0_q <= s_axi_wstrb_i[0];
            end
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel: one read in flight, answer next cycle
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `RESP_OKAY;
        end else begin
            s_axi_arready_o <= !s_axi_rvalid_o && !rd_take;
            if (rd_take) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= {24'h00_0000, rd_byte};
                s_axi_rresp_o <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // run state: idle, running, stopped after error
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_q <= start_on_reset ? ST_RUN : ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (error) begin
                        state_q <= ST_STOP;
                    end else if (trigger) begin
                        state_q <= ST_RUN; // software start
                    end
                end
                // a code with bit 7 low never returns run to idle
                ST_RUN: begin
                    if (error) begin
                        state_q <= ST_STOP;
                    end
                end
                ST_STOP: state_q <= ST_STOP; // only reset leaves
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers: code, reference, mode and the settings in force
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            last_q <= `CODE_RST;
            ref_q <= `REF_RST;
            mode_q <= mode_init;
            act_q <= mode_init;
            first_done_q <= 1'b0;
            mode_wr_q <= 1'b0;
        end else begin
            if (code_wr) begin
                last_q <= wdata_q;
            end
            if (trigger && !error) begin
                ref_q <= ref_q + `REF_STEP;
                act_q <= mode_q; // pending settings apply here
                first_done_q <= 1'b1;
            end
            if (mode_wr && !bad_mode) begin
                mode_q <= {1'b0, wdata_q[6:0]};
                mode_wr_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // prescaler and counter; both freeze once stopped
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            presc_q <= 16'h0000;
            cnt_q <= '0;
        end else if (trigger && !error) begin
            presc_q <= 16'h0000;
            cnt_q <= '0;
        end else if (running && !error) begin
            presc_q <= presc_q + 16'h0001;
            if (tick) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // request outputs, one-cycle pulses
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            warning_irq_o <= 1'b0;
            error_nmi_request_o <= 1'b0;
            error_reset_out_o <= 1'b0;
        end else begin
            // a trigger on the same edge clears the count, so no warning
            warning_irq_o <= warn_hit && !error && !trigger;
            error_nmi_request_o <= error && !act_q.erm;
            error_reset_out_o <= error && act_q.erm;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_stop_sticky: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state_q == ST_STOP |=> state_q == ST_STOP && $stable(cnt_q))
        else $error("stopped watchdog moved");
    a_run_holds: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state_q == ST_RUN |=> state_q != ST_IDLE)
        else $error("run bit cleared without reset");
    a_trig_clears: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        trigger && !error |=> cnt_q == '0 && presc_q == 16'h0000)
        else $error("trigger did not clear counter");
    a_ref_steps: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        trigger && !error |=> ref_q == $past(ref_q) + `REF_STEP)
        else $error("reference not updated");
    a_mode_defer: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !trigger |=> act_q == $past(act_q))
        else $error("mode applied without trigger");
    a_bad_code_err: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        code_wr && !code_ok |=> error_nmi_request_o || error_reset_out_o)
        else $error("wrong code not flagged");
    a_off_ignore: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !variable_code_option_i && wr_lane && wr_code_sel
        |=> last_q == $past(last_q))
        else $error("code write taken with option off");
    a_err_route: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        error |=> (error_reset_out_o == $past(act_q.erm)) &&
                  (error_nmi_request_o != $past(act_q.erm)))
        else $error("error routed to wrong output");
    a_warn_75: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        warning_irq_o |-> cnt_q == CNT_WARN && act_q.wie)
        else $error("warning off its point");
    a_mode_rsvd: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        mode_q.rsvd == 1'b0)
        else $error("reserved mode bit set");
    a_window_err: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        code_wr && code_ok && closed_hit |=> state_q == ST_STOP)
        else $error("closed window trigger accepted");
endmodule
`default_nettype wire

// *** bench/watchdog_code_trigger_regs_tb.sv ***
// self-checking bench for the watchdog code trigger register block
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_code_trigger_regs_map.svh"
module watchdog_code_trigger_regs_tb
    import watchdog_code_trigger_regs_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    localparam int TICK = 512; // source clocks per count at divider 0
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic wen = 1'h1, variable_activation_code = 1'h1, tpr = 1'h0, arun = 1'h0, ttype = 1'h0;
    logic [2:0] divo = 3'h0;
    logic wio = 1'h0;
    logic [1:0] wso = 2'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic warn, nmi, rsto;
    int mismatches = 0, checked = 0, warn_n = 0, nmi_n = 0, rst_n = 0;
    logic [31:0] rd;
    logic [1:0] rsp;

    // 20 MHz source clock
    always #25 clk = ~clk;

    // three bits of count keep one overflow period near 4k cycles
    watchdog_code_trigger_regs #(.CNT_W(3), .ADDR_W(4))
        u_watchdog_code_trigger_regs (
        .sys_clk_i(clk), .srst_i(srst),
        .watchdog_present_option_i(wen), .variable_code_option_i(variable_activation_code),
        .trigger_position_option_i(tpr), .auto_run_option_i(arun),
        .trigger_type_input_i(ttype), .divider_option_i(divo),
        .warning_irq_option_i(wio), .window_size_option_i(wso),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .warning_irq_o(warn),
        .error_nmi_request_o(nmi), .error_reset_out_o(rsto));

    // pulses last one cycle, so count them at every edge
    always @(posedge clk) begin
        if (warn === 1'b1) warn_n <= warn_n + 1;
        if (nmi === 1'b1) nmi_n <= nmi_n + 1;
        if (rsto === 1'b1) rst_n <= rst_n + 1;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic close_out;
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic fail(input string m);
        mismatches++;
        $display("MISMATCH %0t %s", $time, m);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checked++;
        if (got !== exp) fail(m);
    endtask

    // offer address and data together, release each when taken
    // waits as long as the slave needs; only the watchdog ends a hang
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
        logic aw_ok, w_ok;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'h0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'h0;
            end
        end
        do begin
            @(posedge clk);
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'h0;
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
        end while (arready !== 1'b1);
        arvalid <= 1'h0;
        do begin
            @(posedge clk);
        end while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                          input string m);
        axi_rd(a);
        chk(rd, {24'h0, e}, m);
    endtask

    // straps are {present, code option, position, auto run, type}
    task automatic do_reset(input logic [4:0] s, input logic w,
                            input logic [1:0] ws);
        {wen, variable_activation_code, tpr, arun, ttype} <= s;
        wio <= w;
        wso <= ws;
        srst <= 1'h1;
        repeat (6) @(posedge clk);
        srst <= 1'h0;
        repeat (2) @(posedge clk);
        warn_n = 0;
        nmi_n = 0;
        rst_n = 0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_start_run;
        do_reset(5'h1E, 1'h0, 2'h0);
        rd_chk(`OFS_CODE_TRIGGER, 8'h2C, "code reset");
        rd_chk(`OFS_REFERENCE, `REF_RST, "ref reset");
        rd_chk(`OFS_MODE, 8'h04, "mode reset");
        axi_wr(`OFS_REFERENCE, 8'hFF);
        rd_chk(`OFS_REFERENCE, 8'h00, "ref written");
        axi_wr(`OFS_MODE, 8'h8B);
        chk(32'(rsp), 32'(`RESP_OKAY), "mode write resp");
        rd_chk(`OFS_MODE, 8'h0B, "mode bit 7");
        axi_wr(`OFS_MODE, 8'h0B);
        // software start with the first code, window still 100 percent
        axi_wr(`OFS_CODE_TRIGGER, `ACODE_XOR);
        repeat (4 * TICK - 50) @(posedge clk);
        chk(32'(warn_n), 32'h0, "warning too soon");
        repeat (TICK + 150) @(posedge clk);
        chk(32'(warn_n), 32'h1, "warning missing");
        chk(32'(nmi_n + rst_n), 32'h0, "same mode value");
        rd_chk(`OFS_REFERENCE, 8'h01, "ref step");
        rd_chk(`OFS_CODE_TRIGGER, 8'hAC, "run bit set");
        axi_wr(`OFS_CODE_TRIGGER, 8'h01 ^ `ACODE_XOR);
        rd_chk(`OFS_REFERENCE, 8'h02, "ref step 2");
        chk(32'(nmi_n), 32'h0, "good code flagged");
        axi_wr(`OFS_CODE_TRIGGER, 8'h55);
        repeat (4) @(posedge clk);
        chk(32'(nmi_n), 32'h1, "wrong code nmi");
        chk(32'(rst_n), 32'h0, "wrong code reset");
        repeat (6 * TICK) @(posedge clk);
        chk(32'(warn_n + nmi_n), 32'h2, "counter not held");
    endtask

    // erm=1 from reset stays in force until the first trigger
    task automatic t_mode_err;
        do_reset(5'h1D, 1'h1, 2'h1);
        rd_chk(`OFS_CODE_TRIGGER, 8'hAC, "auto start");
        rd_chk(`OFS_MODE, 8'h0D, "mode options");
        axi_wr(`OFS_MODE, 8'h01);
        axi_wr(`OFS_MODE, 8'h00);
        repeat (4) @(posedge clk);
        chk(32'(rst_n), 32'h1, "second mode write");
        chk(32'(nmi_n), 32'h0, "old erm ignored");
    endtask

    task automatic t_window;
        do_reset(5'h1A, 1'h0, 2'h0);
        axi_wr(`OFS_MODE, 8'h00);
        axi_wr(`OFS_CODE_TRIGGER, `ACODE_XOR);
        chk(32'(nmi_n + rst_n), 32'h0, "first trigger");
        axi_wr(`OFS_CODE_TRIGGER, 8'h01 ^ `ACODE_XOR);
        repeat (4) @(posedge clk);
        chk(32'(nmi_n), 32'h1, "closed window");
    endtask

    task automatic t_overflow;
        do_reset(5'h1A, 1'h1, 2'h0);
        repeat (8 * TICK + 200) @(posedge clk);
        chk(32'(warn_n), 32'h1, "option warning");
        chk(32'(rst_n), 32'h1, "overflow reset");
    endtask

    // divider and 75 percent window from the straps; divider in force from reset, window from the first trigger
    task automatic t_div_win;
        divo <= 3'h1;
        do_reset(5'h1A, 1'h1, 2'h2);
        rd_chk(`OFS_MODE, 8'h1E, "mode divider option");
        axi_wr(`OFS_CODE_TRIGGER, `ACODE_XOR);
        repeat (8 * TICK) @(posedge clk);
        chk(32'(warn_n), 32'h0, "divider one too fast");
        axi_wr(`OFS_CODE_TRIGGER, 8'h01 ^ `ACODE_XOR);
        chk(32'(nmi_n + rst_n), 32'h0, "open window trigger");
        axi_wr(`OFS_CODE_TRIGGER, 8'h02 ^ `ACODE_XOR);
        repeat (4) @(posedge clk);
        chk(32'(rst_n), 32'h1, "closed window reset");
    endtask

    task automatic t_vac_off;
        do_reset(5'h12, 1'h0, 2'h0);
        rd_chk(`OFS_CODE_TRIGGER, `CODE_OFF_READ, "off read");
        axi_wr(`OFS_CODE_TRIGGER, `ACODE_XOR);
        rd_chk(`OFS_CODE_TRIGGER, `CODE_OFF_READ, "off write");
        rd_chk(`OFS_REFERENCE, `REF_OFF_READ, "off ref");
        axi_rd(4'h0);
        chk(32'(rsp), 32'(`RESP_SLVERR), "unmapped read resp");
        chk(rd, 32'h0, "unmapped read data");
        axi_wr(4'h0, 8'h12);
        chk(32'(rsp), 32'(`RESP_SLVERR), "unmapped write resp");
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        t_start_run;
        t_mode_err;
        t_window;
        t_overflow;
        t_vac_off;
        t_div_win;
        close_out;
    end

    // the whole run needs about 14k cycles
    initial begin
        repeat (30000) @(posedge clk);
        fail("run hung");
        close_out;
    end
endmodule
`default_nettype wire
